// ===== include/refsel_pkg.sv
package refsel_pkg;
  localparam logic [2:0] PRIO_OFF = 3'h0;
  localparam logic [2:0] PRIO_RESET = 3'h1;
  localparam int CLK_MHZ = 100;
  localparam int XTAL_MIN_MHZ = 10;
  localparam int XTAL_MAX_MHZ = 100;
  localparam int VALID_US_DEFAULT = 10;
  localparam int VALID_CYC_DEFAULT = VALID_US_DEFAULT * CLK_MHZ;
  localparam logic [1:0] MODE_AUTO_REV = 2'h0;
  localparam logic [1:0] MODE_AUTO_NONREV = 2'h1;
  localparam logic [1:0] MODE_MAN_FALLBACK = 2'h2;
  localparam logic [1:0] MODE_MAN_HOLDOVER = 2'h3;
  localparam logic [1:0] HIT_NONE = 2'h0;
  localparam logic [1:0] HIT_CANCEL = 2'h1;
  localparam logic [1:0] HIT_SLEW = 2'h2;
  localparam logic [1:0] HIT_FASTLOCK = 2'h3;

  typedef enum logic [1:0] {ST_FREERUN, ST_LOCKED, ST_HOLDOVER} dpll_state_e;

  typedef struct packed {
    logic [2:0] prio_a;
    logic [2:0] prio_b;
    logic [1:0] mode;
    logic manual_reference_choice;
    logic use_pin_select;
    logic phase_cancel_enable;
    logic phase_slew_enable;
    logic zero_delay_sync;
    logic pps_inputs;
    logic crystal_monitor_bypass;
  } refsel_cfg_s;

  typedef struct packed {
    logic freq_det_en;
    logic phase_valid_en;
    logic freq_flag;
    logic window_flag;
    logic phase_flag;
  } mon_s;
endpackage

// ===== logic/dpll_reference_selector.sv
// Operation
// - Each input has priority 0..7; 0 excludes it, 1 ranks highest.
// - Equal priorities rank the first input ahead of the second.
// - Multiplexer picks between exactly two reference inputs.
// - Selection is automatic by priority or manual by register field or pin.
// - Auto revertive: always highest-priority valid input, switching up at once.
// - Auto non-revertive: keep current input until it turns invalid.
// - Manual modes use field or pin choice while that input stays valid.
// - Manual fallback: invalid choice moves to highest-priority valid input.
// - No valid prioritized input in fallback: holdover if history valid, else free-run.
// - Manual holdover: invalid choice goes straight to holdover or free-run.
// - Manual modes leave holdover once the chosen input is valid again.
// - Selected input identity shows on status pin and status bit.
// - Phase cancellation hides phase step between frequency-locked inputs.
// - Phase slew enable limits transient on holdover exit and unlocked switches.
// - Neither enabled: offset passes at fastlock bandwidth rate.
// - Hitless 1-PPS switching only while zero-delay sync is off.
// - Frequency detector and phase valid detector never both enabled on an input; a clash is only flagged on config_error_r.
// - Crystal loss flag clears only when frequency lies in 10..100 MHz.
// - Crystal bypass makes crystal count valid, loss flag unchanged.
// - Crystal loss flag shows on status pin and status bit.
// - Input valid only after enabled monitors stay clear for validation time.
module dpll_reference_selector #(
  parameter int VALID_CYC = refsel_pkg::VALID_CYC_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire refsel_pkg::refsel_cfg_s cfg,
  input wire logic manual_select_pin,
  input wire refsel_pkg::mon_s mon_a,
  input wire refsel_pkg::mon_s mon_b,
  input wire logic history_valid,
  input wire logic [7:0] crystal_freq_mhz,
  output logic selected_ref_r,
  output logic selected_ref_stat_r,
  output logic ref_active_r,
  output logic holdover_r,
  output logic freerun_r,
  output logic switch_pulse_r,
  output logic [1:0] hitless_mode_r,
  output logic crystal_loss_flag_r,
  output logic crystal_loss_stat_r,
  output logic crystal_valid_r,
  output logic config_error_r
);
  localparam int VW = $clog2(VALID_CYC + 1);
  localparam logic [VW-1:0] VMAX = VW'(VALID_CYC);

  function automatic logic mon_clear(input refsel_pkg::mon_s m);
    mon_clear = !(m.freq_det_en && m.freq_flag) && !m.window_flag && !(m.phase_valid_en && m.phase_flag);
  endfunction

  // Pin select synchroniser: change accepted when stages 2 and 3 agree
  logic pin_s1_r, pin_s2_r, pin_s3_r, pin_sel_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
      pin_sel_r <= 1'b0;
    end else begin
      pin_s1_r <= manual_select_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      if (pin_s2_r == pin_s3_r) pin_sel_r <= pin_s3_r;
    end
  end

  // Validation timers
  logic [VW-1:0] vcnt_a_r, vcnt_b_r;
  wire clr_a = mon_clear(mon_a);
  wire clr_b = mon_clear(mon_b);
  wire valid_a = (vcnt_a_r == VMAX);
  wire valid_b = (vcnt_b_r == VMAX);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vcnt_a_r <= '0;
      vcnt_b_r <= '0;
    end else begin
      vcnt_a_r <= !clr_a ? '0 : (valid_a ? vcnt_a_r : vcnt_a_r + 1'b1);
      vcnt_b_r <= !clr_b ? '0 : (valid_b ? vcnt_b_r : vcnt_b_r + 1'b1);
    end
  end

  // Priority ranking
  wire elig_a = valid_a && (cfg.prio_a != refsel_pkg::PRIO_OFF);
  wire elig_b = valid_b && (cfg.prio_b != refsel_pkg::PRIO_OFF);
  wire a_ranks_first = (cfg.prio_b == refsel_pkg::PRIO_OFF) ||
                       ((cfg.prio_a != refsel_pkg::PRIO_OFF) && (cfg.prio_a <= cfg.prio_b));
  wire best_any = elig_a || elig_b;
  wire best_ref = elig_a && elig_b ? !a_ranks_first : elig_b;

  wire manual_mode = cfg.mode[1];
  wire man_choice = cfg.use_pin_select ? pin_sel_r : cfg.manual_reference_choice;
  wire man_valid = man_choice ? valid_b : valid_a;
  wire cur_valid = selected_ref_r ? valid_b : valid_a;
  wire cur_elig = selected_ref_r ? elig_b : elig_a;

  // Next selection
  logic nxt_active, nxt_ref;
  always_comb begin
    nxt_active = 1'b0;
    nxt_ref = selected_ref_r;
    unique case (cfg.mode)
      refsel_pkg::MODE_AUTO_REV: begin
        nxt_active = best_any;
        nxt_ref = best_any ? best_ref : selected_ref_r;
      end
      refsel_pkg::MODE_AUTO_NONREV: begin
        if (ref_active_r && cur_elig) begin
          nxt_active = 1'b1;
        end else begin
          nxt_active = best_any;
          nxt_ref = best_any ? best_ref : selected_ref_r;
        end
      end
      refsel_pkg::MODE_MAN_FALLBACK: begin
        if (man_valid) begin
          nxt_active = 1'b1;
          nxt_ref = man_choice;
        end else if (ref_active_r && cur_valid && selected_ref_r != man_choice) begin
          nxt_active = 1'b1;
        end else begin
          nxt_active = best_any;
          nxt_ref = best_any ? best_ref : selected_ref_r;
        end
      end
      refsel_pkg::MODE_MAN_HOLDOVER: begin
        nxt_active = man_valid;
        nxt_ref = man_choice;
      end
    endcase
  end

  wire sel_change = nxt_active && ref_active_r && (nxt_ref != selected_ref_r);
  wire acquire = nxt_active && !ref_active_r;
  wire pps_block = cfg.pps_inputs && cfg.zero_delay_sync;

  // Hitless handling for a switchover or a holdover exit
  logic [1:0] hit_nxt;
  always_comb begin
    hit_nxt = hitless_mode_r;
    if (sel_change || acquire) begin
      if (cfg.phase_cancel_enable && sel_change && !pps_block) hit_nxt = refsel_pkg::HIT_CANCEL;
      else if (cfg.phase_slew_enable && !pps_block) hit_nxt = refsel_pkg::HIT_SLEW;
      else hit_nxt = refsel_pkg::HIT_FASTLOCK;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      selected_ref_r <= 1'b0;
      selected_ref_stat_r <= 1'b0;
      ref_active_r <= 1'b0;
      holdover_r <= 1'b0;
      freerun_r <= 1'b1;
      switch_pulse_r <= 1'b0;
      hitless_mode_r <= refsel_pkg::HIT_NONE;
      config_error_r <= 1'b0;
    end else begin
      selected_ref_r <= nxt_ref;
      selected_ref_stat_r <= nxt_ref;
      ref_active_r <= nxt_active;
      holdover_r <= !nxt_active && history_valid;
      freerun_r <= !nxt_active && !history_valid;
      switch_pulse_r <= sel_change;
      hitless_mode_r <= hit_nxt;
      config_error_r <= (mon_a.freq_det_en && mon_a.phase_valid_en) ||
                        (mon_b.freq_det_en && mon_b.phase_valid_en);
    end
  end

  // Crystal coarse frequency monitor
  wire xtal_in_range = (crystal_freq_mhz >= 8'(refsel_pkg::XTAL_MIN_MHZ)) &&
                       (crystal_freq_mhz <= 8'(refsel_pkg::XTAL_MAX_MHZ));
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      crystal_loss_flag_r <= 1'b1;
      crystal_loss_stat_r <= 1'b1;
      crystal_valid_r <= 1'b0;
    end else begin
      crystal_loss_flag_r <= !xtal_in_range;
      crystal_loss_stat_r <= !xtal_in_range;
      crystal_valid_r <= xtal_in_range || cfg.crystal_monitor_bypass;
    end
  end

  sel_mirror_a: assert property (@(posedge ref_clk) disable iff (rst)
    selected_ref_r == selected_ref_stat_r) else $error("Status copy differs from selection");
  valid_timer_a: assert property (@(posedge ref_clk) disable iff (rst)
    !clr_a |=> !valid_a) else $error("Input A valid while flagged");
  excluded_input_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cfg.mode == refsel_pkg::MODE_AUTO_REV && cfg.prio_a == refsel_pkg::PRIO_OFF && $stable(cfg))
    ##1 (cfg.mode == refsel_pkg::MODE_AUTO_REV && cfg.prio_a == refsel_pkg::PRIO_OFF)
    |-> !(ref_active_r && !selected_ref_r)) else $error("Excluded input selected");
  tie_break_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cfg.mode == refsel_pkg::MODE_AUTO_REV && elig_a && elig_b && cfg.prio_a == cfg.prio_b)
    |=> !selected_ref_r) else $error("Tie not broken toward first input");
  nonrev_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cfg.mode == refsel_pkg::MODE_AUTO_NONREV && ref_active_r && cur_elig)
    |=> $stable(selected_ref_r)) else $error("Non-revertive switched from valid input");
  man_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cfg.mode == refsel_pkg::MODE_MAN_HOLDOVER && !man_valid)
    |=> !ref_active_r && (holdover_r != freerun_r)) else $error("Holdover mode tried another input");
  idle_state_a: assert property (@(posedge ref_clk) disable iff (rst)
    !ref_active_r |-> (holdover_r ^ freerun_r)) else $error("Neither holdover nor free-run");
  xtal_bypass_a: assert property (@(posedge ref_clk) disable iff (rst)
    $past(cfg.crystal_monitor_bypass) |-> crystal_valid_r) else $error("Bypass did not force valid");
  xtal_range_a: assert property (@(posedge ref_clk) disable iff (rst)
    (crystal_freq_mhz < 8'(refsel_pkg::XTAL_MIN_MHZ)) |=> crystal_loss_flag_r) else $error("Low crystal not flagged");
  pps_zdm_a: assert property (@(posedge ref_clk) disable iff (rst)
    (pps_block && sel_change) |=> hitless_mode_r == refsel_pkg::HIT_FASTLOCK) else $error("Hitless 1-PPS with zero-delay");

  // Second input timer
  valid_timer_b_a: assert property (@(posedge ref_clk) disable iff (rst)
    !clr_b
    |=> !valid_b)
    else $error("Input B valid while flagged");

  // Automatic selection
  revert_best_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cfg.mode == refsel_pkg::MODE_AUTO_REV && best_any)
    |=> (ref_active_r && selected_ref_r == $past(best_ref)))
    else $error("Revertive mode missed best input");

  auto_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!cfg.mode[1] && !best_any)
    |=> !ref_active_r)
    else $error("Automatic mode active with no input");

  // Manual selection
  man_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
    (manual_mode && man_valid)
    |=> (ref_active_r && selected_ref_r == $past(man_choice)))
    else $error("Manual choice not followed");

  fallback_pick_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cfg.mode == refsel_pkg::MODE_MAN_FALLBACK && !man_valid && !(ref_active_r && cur_valid) && best_any)
    |=> (ref_active_r && selected_ref_r == $past(best_ref)))
    else $error("Fallback missed best input");

  fallback_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cfg.mode == refsel_pkg::MODE_MAN_FALLBACK && !man_valid && !(ref_active_r && cur_valid) && !best_any)
    |=> !ref_active_r)
    else $error("Fallback active with no input");

  // Holdover, free-run and switchover pulse
  history_pick_a: assert property (@(posedge ref_clk) disable iff (rst)
    !nxt_active
    |=> (holdover_r == $past(history_valid)) && (freerun_r == !$past(history_valid)))
    else $error("Holdover or free-run wrong for history");

  active_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
    ref_active_r
    |-> (!holdover_r && !freerun_r))
    else $error("Holdover flag while active");

  switch_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
    sel_change
    |=> switch_pulse_r)
    else $error("Switchover pulse missing");

  // Hitless method
  cancel_pick_a: assert property (@(posedge ref_clk) disable iff (rst)
    (sel_change && cfg.phase_cancel_enable && !pps_block)
    |=> hitless_mode_r == refsel_pkg::HIT_CANCEL)
    else $error("Phase cancellation not applied");

  slew_pick_a: assert property (@(posedge ref_clk) disable iff (rst)
    (acquire && cfg.phase_slew_enable && !pps_block)
    |=> hitless_mode_r == refsel_pkg::HIT_SLEW)
    else $error("Phase slew not applied on acquire");

  fastlock_pick_a: assert property (@(posedge ref_clk) disable iff (rst)
    ((sel_change || acquire) && !cfg.phase_cancel_enable && !cfg.phase_slew_enable)
    |=> hitless_mode_r == refsel_pkg::HIT_FASTLOCK)
    else $error("Fastlock not applied");

  // Crystal monitor
  xtal_copy_a: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1
    |-> crystal_loss_flag_r == crystal_loss_stat_r)
    else $error("Crystal status copy differs");

  xtal_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    xtal_in_range
    |=> !crystal_loss_flag_r)
    else $error("In-range crystal still flagged");

  xtal_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cfg.crystal_monitor_bypass && !xtal_in_range)
    |=> crystal_loss_flag_r)
    else $error("Bypass cleared crystal loss flag");

  // Configuration and pin filter
  cfg_clash_a: assert property (@(posedge ref_clk) disable iff (rst)
    ((mon_a.freq_det_en && mon_a.phase_valid_en) || (mon_b.freq_det_en && mon_b.phase_valid_en))
    |=> config_error_r)
    else $error("Detector clash not reported");

  pin_filter_a: assert property (@(posedge ref_clk) disable iff (rst)
    (pin_s2_r != pin_s3_r)
    |=> $stable(pin_sel_r))
    else $error("Pin choice taken before stages agree");
endmodule // dpll_reference_selector

// ===== tb/ref_source_model.sv
module ref_source_model (
  input wire logic bad_a,
  input wire logic bad_b,
  input wire logic clash,
  output refsel_pkg::mon_s mon_a,
  output refsel_pkg::mon_s mon_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // Frequency detector only; phase valid joins it on the first input only when a clash is asked
  // Gaps stay within one divided period, so only a real fault raises a flag
  assign mon_a = '{freq_det_en: 1'b1, phase_valid_en: clash, freq_flag: bad_a, window_flag: bad_a, phase_flag: 1'b0};
  assign mon_b = '{freq_det_en: 1'b1, phase_valid_en: 1'b0, freq_flag: bad_b, window_flag: bad_b, phase_flag: 1'b0};
endmodule // ref_source_model

// ===== tb/dpll_reference_selector_bench.sv
module dpll_reference_selector_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int VC = 4;
  localparam int SETTLE = VC + 8;
  typedef struct packed {
    logic [2:0] pa;
    logic [2:0] pb;
    logic [1:0] md;
    logic man;
    logic ba;
    logic bb;
    logic hv;
    logic [3:0] ex;
  } row_s;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic pin = 1'b0;
  logic hv = 1'b1;
  logic bad_a = 1'b0;
  logic bad_b = 1'b0;
  logic clash = 1'b0;
  logic [7:0] xf = 8'h32;
  refsel_pkg::refsel_cfg_s cfg = '0;
  refsel_pkg::mon_s mon_a, mon_b;
  logic sel, sel_st, act, hold, free, sw, xl, xl_st, xv, cerr;
  logic [1:0] hit;
  int err_count = 0;
  int compares = 0;
  int pulses = 0;
  row_s rows[14];
  logic [7:0] xfreq[4] = '{8'h09, 8'h0a, 8'h64, 8'h65};
  logic xloss[4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  dpll_reference_selector #(.VALID_CYC(VC)) uut (.ref_clk(ref_clk), .rst(rst), .cfg(cfg), .manual_select_pin(pin),
    .mon_a(mon_a), .mon_b(mon_b), .history_valid(hv), .crystal_freq_mhz(xf), .selected_ref_r(sel),
    .selected_ref_stat_r(sel_st), .ref_active_r(act), .holdover_r(hold), .freerun_r(free), .switch_pulse_r(sw),
    .hitless_mode_r(hit), .crystal_loss_flag_r(xl), .crystal_loss_stat_r(xl_st), .crystal_valid_r(xv),
    .config_error_r(cerr));
  ref_source_model partner (.bad_a(bad_a), .bad_b(bad_b), .clash(clash), .mon_a(mon_a), .mon_b(mon_b));

  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (sw === 1'b1) pulses <= pulses + 1;

  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic hit_case(input logic c, input logic s, input logic pz, input logic [1:0] exp);
    int p0;
    p0 = pulses;
    @(posedge ref_clk);
    cfg.phase_cancel_enable <= c;
    cfg.phase_slew_enable <= s;
    cfg.pps_inputs <= pz;
    cfg.zero_delay_sync <= pz;
    bad_a <= ~bad_a;
    wait_n(SETTLE);
    chk({hit, 2'h0}, {exp, 2'h0}, "hitless");
    chk(4'(pulses - p0), 4'h1, "pulse");
  endtask

  task automatic give_verdict();
    $display("Mismatches %0d, compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    wait_n(5000);
    err_count++;
    give_verdict();
  end

  initial begin
    rows = '{'{3'h1, 3'h2, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h4}, '{3'h2, 3'h1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 4'hc},
      '{3'h1, 3'h1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h4}, '{3'h0, 3'h3, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 4'hc},
      '{3'h1, 3'h2, 2'h1, 1'b0, 1'b0, 1'b0, 1'b1, 4'hc}, '{3'h1, 3'h2, 2'h1, 1'b0, 1'b0, 1'b1, 1'b1, 4'h4},
      '{3'h1, 3'h2, 2'h2, 1'b1, 1'b0, 1'b0, 1'b1, 4'hc}, '{3'h1, 3'h2, 2'h2, 1'b1, 1'b0, 1'b1, 1'b1, 4'h4},
      '{3'h1, 3'h2, 2'h2, 1'b1, 1'b1, 1'b1, 1'b1, 4'h2}, '{3'h1, 3'h2, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 4'hc},
      '{3'h1, 3'h2, 2'h3, 1'b0, 1'b1, 1'b0, 1'b0, 4'h1}, '{3'h1, 3'h2, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 4'h4},
      '{3'h1, 3'h2, 2'h0, 1'b0, 1'b1, 1'b1, 1'b1, 4'h2}, '{3'h0, 3'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h2}};
    wait_n(19);
    chk({sel, act, hold, free}, 4'h1, "reset state");
    chk({hit, xl, xv}, 4'h2, "reset flags");
    @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      @(posedge ref_clk);
      cfg.prio_a <= rows[i].pa;
      cfg.prio_b <= rows[i].pb;
      cfg.mode <= rows[i].md;
      cfg.manual_reference_choice <= rows[i].man;
      bad_a <= rows[i].ba;
      bad_b <= rows[i].bb;
      hv <= rows[i].hv;
      wait_n(SETTLE);
      chk({sel & rows[i].ex[2], act, hold, free}, rows[i].ex, "row");
      chk({sel_st, xl_st, 2'h0}, {sel, xl, 2'h0}, "status copy");
    end
    @(posedge ref_clk);
    cfg.prio_a <= 3'h1;
    cfg.prio_b <= 3'h2;
    bad_a <= 1'b0;
    bad_b <= 1'b0;
    wait_n(SETTLE);
    hit_case(1'b1, 1'b0, 1'b0, refsel_pkg::HIT_CANCEL);
    hit_case(1'b0, 1'b1, 1'b0, refsel_pkg::HIT_SLEW);
    hit_case(1'b0, 1'b0, 1'b0, refsel_pkg::HIT_FASTLOCK);
    hit_case(1'b1, 1'b0, 1'b1, refsel_pkg::HIT_FASTLOCK); // 1-PPS with zero-delay sync blocks cancellation, so fastlock
    @(posedge ref_clk);
    cfg.mode <= refsel_pkg::MODE_MAN_FALLBACK;
    cfg.use_pin_select <= 1'b1;
    pin <= 1'b1;
    wait_n(SETTLE + 4);
    chk({sel, act, 2'h0}, 4'hc, "pin b");
    @(posedge ref_clk);
    pin <= 1'b0;
    wait_n(SETTLE + 4);
    chk({sel, act, 2'h0}, 4'h4, "pin a");
    foreach (xfreq[i]) begin
      @(posedge ref_clk);
      xf <= xfreq[i];
      wait_n(3);
      chk({xl, xv, xl_st, 1'b0}, {xloss[i], ~xloss[i], xloss[i], 1'b0}, "crystal");
    end
    @(posedge ref_clk);
    cfg.crystal_monitor_bypass <= 1'b1;
    xf <= 8'h09;
    wait_n(3);
    chk({xl, xv, 2'h0}, 4'hc, "bypass");
    @(posedge ref_clk);
    clash <= 1'b1;
    wait_n(3);
    chk({cerr, 3'h0}, 4'h8, "clash");
    give_verdict();
  end
endmodule // dpll_reference_selector_bench
